/* File: hw/smps_pkg.sv */
package smps_pkg;

   // ==========================================================
   // Internal I/O map, low byte only
   // ==========================================================
   localparam logic [7:0] SMPS_ADDR_WAIT_CONFIG  = 8'h1b;
   localparam logic [7:0] SMPS_ADDR_IRQ_ROUTING  = 8'h1c;
   localparam logic [7:0] SMPS_ADDR_PIN_SELECT_B = 8'h1d;
   localparam logic [7:0] SMPS_ADDR_PIN_SELECT_C = 8'h1e;
   localparam logic [7:0] SMPS_ADDR_PIN_SELECT_D = 8'h1f;

   // ==========================================================
   // Reset values: slowest waits, switchable shared inputs (IRQ 0/1/2/5, NMI, DMA B, CTS/DSR) disconnected
   // ==========================================================
   localparam logic [7:0] SMPS_RST_WAIT_CONFIG  = 8'hc0;
   localparam logic [7:0] SMPS_RST_IRQ_ROUTING  = 8'h00;
   localparam logic [7:0] SMPS_RST_PIN_SELECT_B = 8'h02;
   localparam logic [7:0] SMPS_RST_PIN_SELECT_C = 8'h00;
   localparam logic [7:0] SMPS_RST_PIN_SELECT_D = 8'h00;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SMPS_WC_MEM_LO  = 4;
   localparam int SMPS_WC_MEM_HI  = 5;
   localparam int SMPS_WC_IO_LO   = 6;
   localparam int SMPS_WC_IO_HI   = 7;
   localparam int SMPS_IR_INV_LO  = 0;
   localparam int SMPS_IR_INV_HI  = 3;
   localparam int SMPS_IR_EN0     = 4;
   localparam int SMPS_IR_EN1     = 5;
   localparam int SMPS_IR_EN2     = 6;
   localparam int SMPS_IR_EN5     = 7;
   localparam int SMPS_PB_DREQ_HI = 1;
   localparam int SMPS_PB_FUNC_LO = 4;
   localparam int SMPS_PB_FUNC_HI = 5;
   localparam int SMPS_PB_PIN5_LO = 6;
   localparam int SMPS_PB_PIN5_HI = 7;
   localparam int SMPS_PC_NMI_LO  = 6;
   localparam int SMPS_PC_NMI_HI  = 7;
   localparam int SMPS_PD_OUT_LO  = 0;
   localparam int SMPS_PD_OUT_HI  = 1;
   localparam int SMPS_PD_TXS     = 2;
   localparam int SMPS_PD_P1_LO   = 3;
   localparam int SMPS_PD_P1_HI   = 7;

   // ==========================================================
   // Wait encodings
   // ==========================================================
   localparam logic [1:0] SMPS_IO_WAIT_FOUR = 2'h3;
   localparam logic [2:0] SMPS_IO_WAIT_BASE = 3'h1;
   localparam logic [1:0] SMPS_NMI_ON       = 2'h2;

   typedef enum logic [1:0] {
      SMPS_MODE_NORMAL = 2'h1,
      SMPS_MODE_DEBUG  = 2'h2
   } smps_mode_t;

endpackage : smps_pkg

/* File: hw/smps_top.sv */
`timescale 1ns/1ns
// Behaviour
// - Operating mode comes from boot-mode pin alone; control registers set waits and pins.
// - Boot-mode pin high selects debug boot mode, else normal mode.
// - Five system control registers, first at I/O address 1BH.
// - Wait D5:D4: 0X one/one, 10 one/zero, 11 zero/zero; DRAM excluded.
// - Wait D7:D6 give one to four I/O waits, three to six clocks.
// - Four I/O waits delays I/O strobe leading edge by half clock.
// - Pin 5 always output; function chosen by third register field.
// - Four input pins feed port-0 bit and timer gate; two feed UART clocks.
// - Three fixed output pins take functions from fifth register fields.
// - Serial receive pins follow port direction; port outputs feed receivers.
// - Handshake pins feed UART inputs only when third register D5:D4 is 1X.
// - Port3 bit3 output with fifth D2 set drives and reads serial transmit.
// - Three pins forced output unless used as ports; then direction register.
// - Port2 bit7 feeds NMI when fourth D7:D6 is 10; D7 clear disconnects.
// - Second register D7/D5 and D6/D4 connect IRQ 5/1 and 2/0 to pins.
// - Second register D3:D0 chooses direct or inverted IRQ pin levels.
// - Port-1 pins forced output when reassigned, except serial clock pin.
// - Serial clock pin as input feeds port1 bit0 and serial clock input.
// - Register decode uses the low eight address bits only.
module smps_top
   import smps_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Boot mode strap
   input  wire logic       boot_mode_pin_i,
   // Internal I/O bus
   input  wire logic [15:0] io_addr_i,
   input  wire logic [7:0] io_wdata_i,
   input  wire logic       io_wr_i,
   input  wire logic       io_rd_i,
   output logic      [7:0] io_rdata_o,
   output logic            io_hit_o,
   // Mode and timing
   output logic            debug_boot_o,
   output logic      [1:0] mem_wait_lo_o,
   output logic      [1:0] mem_wait_hi_o,
   output logic      [2:0] io_wait_o,
   output logic            io_strobe_half_delay_o,
   // Function selects for fixed outputs
   output logic      [1:0] pin5_func_o,
   output logic      [1:0] out_pins_func_o,
   // Fixed input pins 12,13,17,18 (port0 bits 7..4)
   input  wire logic [3:0] fixed_in_pins_i,
   output logic      [3:0] port0_in_hi_o,
   output logic      [3:0] timer_gate_o,
   output logic            uart_clock_in_a_o,
   output logic            uart_clock_in_b_o,
   // Port 3 bits 7..3
   input  wire logic [7:3] port3_pin_i,
   input  wire logic [7:3] port3_out_i,
   input  wire logic [7:3] port3_dir_i,
   input  wire logic       csio_tx_b_i,
   output logic      [7:3] port3_pin_o,
   output logic      [7:3] port3_oe_o,
   output logic      [7:3] port3_in_o,
   output logic            csio_rx_b_o,
   output logic            uart_rx_b_o,
   output logic            uart_clear_to_send_b_o,
   output logic            uart_set_ready_b_o,
   // Port 2 (pins 77,80,81 on bits 2..0 of the forced group)
   input  wire logic [7:0] port2_pin_i,
   input  wire logic [7:0] port2_out_i,
   input  wire logic [7:0] port2_dir_i,
   input  wire logic [2:0] port2_func_out_i,
   output logic      [7:0] port2_pin_o,
   output logic      [7:0] port2_oe_o,
   output logic      [7:0] port2_in_o,
   output logic            nmi_in_o,
   output logic            ext_bus_ack_in_o,
   output logic            dma_request_a_o,
   output logic            dma_request_b_o,
   output logic            irq_line_0_o,
   output logic            irq_line_1_o,
   output logic            irq_line_2_o,
   output logic            irq_line_5_o,
   output logic            irq_line_14_o,
   output logic            irq_line_15_o,
   // Port 1
   input  wire logic [7:0] port1_pin_i,
   input  wire logic [7:0] port1_out_i,
   input  wire logic [7:0] port1_dir_i,
   input  wire logic [7:1] port1_func_out_i,
   input  wire logic       csio_clock_b_out_i,
   input  wire logic       csio_clock_b_oe_i,
   output logic      [7:0] port1_pin_o,
   output logic      [7:0] port1_oe_o,
   output logic      [7:0] port1_in_o,
   output logic            csio_clock_b_o
);

   // =============================================================
   // Register file
   // =============================================================
   logic [7:0] wait_config_q, wait_config_d;
   logic [7:0] irq_routing_q, irq_routing_d;
   logic [7:0] pin_sel_b_q,   pin_sel_b_d;
   logic [7:0] pin_sel_c_q,   pin_sel_c_d;
   logic [7:0] pin_sel_d_q,   pin_sel_d_d;
   logic [7:0] rdata_q,       rdata_d;
   logic       hit_q,         hit_d;

   // Low byte decode; upper address byte is ignored
   function automatic logic sel(input logic [15:0] a,
                                input logic [7:0]  o);
      sel = (a[7:0] == o);
   endfunction : sel

   // Next-state for registers and read data
   always_comb begin
      wait_config_d = wait_config_q;
      irq_routing_d = irq_routing_q;
      pin_sel_b_d   = pin_sel_b_q;
      pin_sel_c_d   = pin_sel_c_q;
      pin_sel_d_d   = pin_sel_d_q;
      rdata_d       = 8'h00;
      hit_d         = 1'b0;
      if (io_wr_i) begin
         if (sel(io_addr_i, SMPS_ADDR_WAIT_CONFIG)) begin
            wait_config_d = io_wdata_i;
         end
         if (sel(io_addr_i, SMPS_ADDR_IRQ_ROUTING)) begin
            irq_routing_d = io_wdata_i;
         end
         if (sel(io_addr_i, SMPS_ADDR_PIN_SELECT_B)) begin
            pin_sel_b_d = io_wdata_i;
         end
         if (sel(io_addr_i, SMPS_ADDR_PIN_SELECT_C)) begin
            pin_sel_c_d = io_wdata_i;
         end
         if (sel(io_addr_i, SMPS_ADDR_PIN_SELECT_D)) begin
            pin_sel_d_d = io_wdata_i;
         end
      end
      // Read beside a write returns the old value
      if (io_rd_i) begin
         hit_d = 1'b1;
         case (io_addr_i[7:0])
            SMPS_ADDR_WAIT_CONFIG:  rdata_d = wait_config_q;
            SMPS_ADDR_IRQ_ROUTING:  rdata_d = irq_routing_q;
            SMPS_ADDR_PIN_SELECT_B: rdata_d = pin_sel_b_q;
            SMPS_ADDR_PIN_SELECT_C: rdata_d = pin_sel_c_q;
            SMPS_ADDR_PIN_SELECT_D: rdata_d = pin_sel_d_q;
            default:                hit_d   = 1'b0;
         endcase
      end
   end

   // Registers; defaults keep waits slowest after reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_config_q <= SMPS_RST_WAIT_CONFIG;
         irq_routing_q <= SMPS_RST_IRQ_ROUTING;
         pin_sel_b_q   <= SMPS_RST_PIN_SELECT_B;
         pin_sel_c_q   <= SMPS_RST_PIN_SELECT_C;
         pin_sel_d_q   <= SMPS_RST_PIN_SELECT_D;
         rdata_q       <= 8'h00;
         hit_q         <= 1'b0;
      end else begin
         wait_config_q <= wait_config_d;
         irq_routing_q <= irq_routing_d;
         pin_sel_b_q   <= pin_sel_b_d;
         pin_sel_c_q   <= pin_sel_c_d;
         pin_sel_d_q   <= pin_sel_d_d;
         rdata_q       <= rdata_d;
         hit_q         <= hit_d;
      end
   end

   assign io_rdata_o = rdata_q;
   assign io_hit_o   = hit_q;

   // =============================================================
   // Operating mode and wait decode
   // =============================================================
   smps_mode_t mode_d;
   logic       debug_q, debug_d;
   logic [1:0] mem_lo_q, mem_lo_d, mem_hi_q, mem_hi_d;
   logic [2:0] io_wait_q, io_wait_d;
   logic       half_q, half_d;
   logic [1:0] pin5_q, pin5_d, outf_q, outf_d;
   logic [1:0] mf, iof;

   // Strap is sampled by the clock; reset loads normal mode (debug clear)
   always_comb begin
      mode_d = boot_mode_pin_i ? SMPS_MODE_DEBUG
                               : SMPS_MODE_NORMAL;
      case (mode_d)
         SMPS_MODE_NORMAL: debug_d = 1'b0;
         SMPS_MODE_DEBUG:  debug_d = 1'b1;
         default:          debug_d = 1'b0;
      endcase
      mf  = wait_config_q[SMPS_WC_MEM_HI:SMPS_WC_MEM_LO];
      iof = wait_config_q[SMPS_WC_IO_HI:SMPS_WC_IO_LO];
      // Low region waits one unless bits 5 and 4 both set, high unless bit 5 set; DRAM uses its own count
      mem_lo_d = {1'b0, ~(mf[1] & mf[0])};
      mem_hi_d = {1'b0, ~mf[1]};
      // Bus unit makes the half-clock shift; flag only
      io_wait_d = SMPS_IO_WAIT_BASE + {1'b0, iof};
      half_d    = (iof == SMPS_IO_WAIT_FOUR);
      pin5_d = pin_sel_b_q[SMPS_PB_PIN5_HI:SMPS_PB_PIN5_LO];
      outf_d = pin_sel_d_q[SMPS_PD_OUT_HI:SMPS_PD_OUT_LO];
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         debug_q   <= 1'b0;
         mem_lo_q  <= 2'h1;
         mem_hi_q  <= 2'h1;
         io_wait_q <= 3'h4;
         half_q    <= 1'b1;
         pin5_q    <= 2'h0;
         outf_q    <= 2'h0;
      end else begin
         debug_q   <= debug_d;
         mem_lo_q  <= mem_lo_d;
         mem_hi_q  <= mem_hi_d;
         io_wait_q <= io_wait_d;
         half_q    <= half_d;
         pin5_q    <= pin5_d;
         outf_q    <= outf_d;
      end
   end

   assign debug_boot_o           = debug_q;
   assign mem_wait_lo_o          = mem_lo_q;
   assign mem_wait_hi_o          = mem_hi_q;
   assign io_wait_o              = io_wait_q;
   assign io_strobe_half_delay_o = half_q;
   assign pin5_func_o            = pin5_q;
   assign out_pins_func_o        = outf_q;

   // =============================================================
   // Shared pin routing
   // =============================================================
   logic [7:0] p1_pin_d, p1_oe_d, p1_in_d, p2_pin_d, p2_oe_d, p2_in_d;
   logic [7:3] p3_pin_d, p3_oe_d, p3_in_d;
   logic [3:0] ir_lvl;
   logic       func_en, txs_en, nmi_en;
   logic [24:0] rt_d, rt_q;
   logic [7:0]  p1_pin_q, p1_oe_q, p1_in_q;
   logic [7:0]  p2_pin_q, p2_oe_q, p2_in_q;
   logic [14:0] p3_q;

   // Effective pin level: own output when driving, else the pad
   always_comb begin
      func_en = pin_sel_b_q[SMPS_PB_FUNC_HI];
      txs_en  = pin_sel_d_q[SMPS_PD_TXS];
      nmi_en  = (pin_sel_c_q[SMPS_PC_NMI_HI:SMPS_PC_NMI_LO] == SMPS_NMI_ON);
      // Port 3: direction register only; TXS replaces bit 3 output
      p3_oe_d  = port3_dir_i;
      p3_pin_d = port3_out_i;
      if (txs_en) begin
         p3_pin_d[3] = csio_tx_b_i;
      end
      // Port read of an output returns its driven level
      p3_in_d = (p3_oe_d & p3_pin_d) | (~p3_oe_d & port3_pin_i);
      // Port 2: pins 77,80,81 forced output when used as functions
      p2_oe_d  = port2_dir_i;
      p2_pin_d = port2_out_i;
      if (func_en) begin
         p2_oe_d[2:0]  = 3'h7;
         p2_pin_d[2:0] = port2_func_out_i;
      end
      p2_in_d = (p2_oe_d & p2_pin_d) | (~p2_oe_d & port2_pin_i);
      // Polarity first, so a disabled request reads low
      ir_lvl = {p2_in_d[1], p2_in_d[1], p2_in_d[0], p2_in_d[0]}
               ^ irq_routing_q[SMPS_IR_INV_HI:SMPS_IR_INV_LO];
      // Port 1: reassigned pins forced output; bit 0 owned by serial clock
      p1_oe_d  = port1_dir_i;
      p1_pin_d = port1_out_i;
      // Five selects for seven bits: 1 with 6, 2 with 7
      for (int i = 1; i < 8; i++) begin
         if (pin_sel_d_q[SMPS_PD_P1_LO + ((i - 1) % 5)]) begin
            p1_oe_d[i]  = 1'b1;
            p1_pin_d[i] = port1_func_out_i[i];
         end
      end
      p1_oe_d[0]  = csio_clock_b_oe_i;
      p1_pin_d[0] = csio_clock_b_out_i;
      p1_in_d = (p1_oe_d & p1_pin_d) | (~p1_oe_d & port1_pin_i);
      // One register stage: pins lag their pads a clock
      rt_d = {
         fixed_in_pins_i,
         fixed_in_pins_i,
         fixed_in_pins_i[1], fixed_in_pins_i[0],
         p3_in_d[7], p3_in_d[6],
         func_en & p3_in_d[5], func_en & p3_in_d[4],
         nmi_en & p2_in_d[7],
         p2_in_d[6], p2_in_d[4],
         ~pin_sel_b_q[SMPS_PB_DREQ_HI] & p2_in_d[5],
         irq_routing_q[SMPS_IR_EN0] & ir_lvl[0],
         irq_routing_q[SMPS_IR_EN1] & ir_lvl[2],
         irq_routing_q[SMPS_IR_EN2] & ir_lvl[1],
         irq_routing_q[SMPS_IR_EN5] & ir_lvl[3],
         p2_in_d[2], p2_in_d[3],
         p1_in_d[0]};
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rt_q     <= '0;
         p1_pin_q <= 8'h00;
         p1_oe_q  <= 8'h00;
         p1_in_q  <= 8'h00;
         p2_pin_q <= 8'h00;
         p2_oe_q  <= 8'h00;
         p2_in_q  <= 8'h00;
         p3_q     <= '0;
      end else begin
         rt_q     <= rt_d;
         p1_pin_q <= p1_pin_d;
         p1_oe_q  <= p1_oe_d;
         p1_in_q  <= p1_in_d;
         p2_pin_q <= p2_pin_d;
         p2_oe_q  <= p2_oe_d;
         p2_in_q  <= p2_in_d;
         p3_q     <= {p3_pin_d, p3_oe_d, p3_in_d};
      end
   end

   // Output unpacking; every signal leaves from a flip-flop
   assign {port0_in_hi_o, timer_gate_o,
           uart_clock_in_b_o, uart_clock_in_a_o,
           csio_rx_b_o, uart_rx_b_o,
           uart_clear_to_send_b_o, uart_set_ready_b_o,
           nmi_in_o, ext_bus_ack_in_o, dma_request_a_o, dma_request_b_o,
           irq_line_0_o, irq_line_1_o, irq_line_2_o, irq_line_5_o,
           irq_line_14_o, irq_line_15_o, csio_clock_b_o} = rt_q;
   assign port1_pin_o = p1_pin_q;
   assign port1_oe_o  = p1_oe_q;
   assign port1_in_o  = p1_in_q;
   assign port2_pin_o = p2_pin_q;
   assign port2_oe_o  = p2_oe_q;
   assign port2_in_o  = p2_in_q;
   assign {port3_pin_o, port3_oe_o, port3_in_o} = p3_q;

endmodule : smps_top

/* File: tb/smps_chk.sv */
`timescale 1ns/1ns
// ==========================================================
// Port checks for the mode and pin-sharing block
// ==========================================================
module smps_chk (
   // Clock, reset, strap
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        boot_mode_pin_i,
   input  wire logic        debug_boot_o,
   // Register bus
   input  wire logic [15:0] io_addr_i,
   input  wire logic [7:0]  io_wdata_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_rdata_o,
   input  wire logic        io_hit_o,
   // Waits
   input  wire logic [2:0]  io_wait_o,
   input  wire logic        io_strobe_half_delay_o,
   input  wire logic [1:0]  mem_wait_lo_o,
   input  wire logic [1:0]  mem_wait_hi_o,
   // Shared pins
   input  wire logic [3:0]  fixed_in_pins_i,
   input  wire logic [3:0]  timer_gate_o,
   input  wire logic [3:0]  port0_in_hi_o,
   input  wire logic        uart_clock_in_a_o,
   input  wire logic        uart_clock_in_b_o,
   input  wire logic [7:3]  port3_dir_i,
   input  wire logic [7:3]  port3_oe_o,
   input  wire logic [7:3]  port3_in_o,
   input  wire logic        csio_rx_b_o,
   input  wire logic        uart_rx_b_o,
   input  wire logic [7:0]  port2_in_o,
   input  wire logic        ext_bus_ack_in_o,
   input  wire logic        dma_request_a_o,
   input  wire logic [7:0]  port1_in_o,
   input  wire logic        csio_clock_b_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   // Upper address byte is ignored, so only the low byte decides a hit
   wire logic rd_map = io_addr_i[7:0] >= 8'h1b && io_addr_i[7:0] <= 8'h1f;

   // Bus steps on the wait register
   sequence s_wr_wait;
      io_wr_i && io_addr_i[7:0] == 8'h1b;
   endsequence
   sequence s_rd_wait;
      io_rd_i && !io_wr_i && io_addr_i[7:0] == 8'h1b;
   endsequence

   property p_io_wait;
      s_wr_wait |-> ##2 io_wait_o == {1'b0, $past(io_wdata_i[7:6], 2)} + 3'h1;
   endproperty
   // Idle cycles between write and read let the write land
   property p_readback;
      s_wr_wait ##1 !io_wr_i [*3] ##1 s_rd_wait |=>
         io_rdata_o == $past(io_wdata_i, 5);
   endproperty
   property p_half;
      io_strobe_half_delay_o == (io_wait_o == 3'h4);
   endproperty
   property p_mem;
      mem_wait_lo_o <= 2'h1 && mem_wait_hi_o <= mem_wait_lo_o;
   endproperty
   property p_hit;
      io_rd_i && rd_map |=> io_hit_o;
   endproperty
   property p_miss;
      io_rd_i && !rd_map |=> !io_hit_o && io_rdata_o == 8'h00;
   endproperty
   property p_boot;
      (boot_mode_pin_i [*2] |-> debug_boot_o) and
      (!boot_mode_pin_i [*2] |-> !debug_boot_o);
   endproperty
   property p_gate;
      $stable(fixed_in_pins_i) |=> timer_gate_o == $past(fixed_in_pins_i)
         && port0_in_hi_o == timer_gate_o
         && uart_clock_in_a_o == timer_gate_o[0]
         && uart_clock_in_b_o == timer_gate_o[1];
   endproperty
   // Receive pins keep the port direction whatever the system setting
   property p_rx;
      $past(rst_n_i) |-> port3_oe_o[7:6] == $past(port3_dir_i[7:6])
         && csio_rx_b_o == port3_in_o[7] && uart_rx_b_o == port3_in_o[6];
   endproperty
   property p_shared;
      ext_bus_ack_in_o == port2_in_o[6] && dma_request_a_o == port2_in_o[4]
         && csio_clock_b_o == port1_in_o[0];
   endproperty

   a_io_wait: assert property (p_io_wait)
      else $error("io wait count wrong");
   a_readback: assert property (p_readback)
      else $error("wait register readback wrong");
   a_half: assert property (p_half)
      else $error("strobe delay flag wrong");
   a_mem: assert property (p_mem)
      else $error("memory wait pattern wrong");
   a_hit: assert property (p_hit)
      else $error("mapped read missed");
   a_miss: assert property (p_miss)
      else $error("unmapped read answered");
   a_boot: assert property (p_boot)
      else $error("boot mode wrong");
   a_gate: assert property (p_gate)
      else $error("fixed input fan-out wrong");
   a_rx: assert property (p_rx)
      else $error("receive pin routing wrong");
   a_shared: assert property (p_shared)
      else $error("shared input routing wrong");
endmodule : smps_chk

bind smps_top smps_chk u_smps_chk (.*);

/* File: tb/smps_board.sv */
`timescale 1ns/1ns
// ==========================================================
// Board model: each pad resolves chip drive against board drive
// ==========================================================
module smps_board (
   // Chip pad drive
   input  wire logic [7:0] port1_pin_o,
   input  wire logic [7:0] port1_oe_o,
   input  wire logic [7:0] port2_pin_o,
   input  wire logic [7:0] port2_oe_o,
   input  wire logic [7:3] port3_pin_o,
   input  wire logic [7:3] port3_oe_o,
   // Board drive, yielded wherever the chip drives
   input  wire logic [7:0] ext1_i,
   input  wire logic [7:0] ext2_i,
   input  wire logic [7:3] ext3_i,
   // Resolved pad levels back to the chip
   output logic      [7:0] port1_pin_i,
   output logic      [7:0] port2_pin_i,
   output logic      [7:3] port3_pin_i
);
   // Chip wins where it drives, so no pad ever sees two drivers
   assign port1_pin_i = (port1_oe_o & port1_pin_o) | (~port1_oe_o & ext1_i);
   assign port2_pin_i = (port2_oe_o & port2_pin_o) | (~port2_oe_o & ext2_i);
   assign port3_pin_i = (port3_oe_o & port3_pin_o) | (~port3_oe_o & ext3_i);
endmodule : smps_board

/* File: tb/tb.sv */
`timescale 1ns/1ns
// ==========================================================
// Bench for the mode and pin-sharing block
// ==========================================================
module tb;
   import smps_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic boot_mode_pin_i, io_wr_i, io_rd_i, io_hit_o, debug_boot_o;
   logic [15:0] io_addr_i;
   logic [7:0] io_wdata_i, io_rdata_o, ext1_i, ext2_i, e;
   logic io_strobe_half_delay_o, uart_clock_in_a_o, uart_clock_in_b_o;
   logic [1:0] mem_wait_lo_o, mem_wait_hi_o, pin5_func_o, out_pins_func_o;
   logic [2:0] io_wait_o, port2_func_out_i;
   logic [3:0] fixed_in_pins_i, port0_in_hi_o, timer_gate_o;
   logic csio_tx_b_i, csio_rx_b_o, uart_rx_b_o, nmi_in_o;
   logic uart_clear_to_send_b_o, uart_set_ready_b_o;
   logic [7:3] port3_pin_i, port3_out_i, port3_dir_i, ext3_i;
   logic [7:3] port3_pin_o, port3_oe_o, port3_in_o;
   logic [7:0] port2_pin_i, port2_out_i, port2_dir_i;
   logic [7:0] port2_pin_o, port2_oe_o, port2_in_o;
   logic [7:0] port1_pin_i, port1_out_i, port1_dir_i;
   logic [7:0] port1_pin_o, port1_oe_o, port1_in_o;
   logic [7:1] port1_func_out_i;
   logic ext_bus_ack_in_o, dma_request_a_o, dma_request_b_o, irq_line_0_o;
   logic irq_line_1_o, irq_line_2_o, irq_line_5_o, irq_line_14_o;
   logic irq_line_15_o, csio_clock_b_out_i, csio_clock_b_oe_i;
   logic csio_clock_b_o, inv;
   logic [7:0] rst_v [5];
   int num_errors = 0;
   int checks_done = 0;

   smps_top   u_smps_top (.*);
   smps_board u_smps_board (.*);

   // 100 MHz system clock
   always #5 clk_sys_i = ~clk_sys_i;

   task automatic chk(input string what, input logic [7:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask : chk
   // Leaves us 1 ns after an edge, where every input change is made
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step
   // Settings show one cycle after the write edge; wait two spare
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      io_addr_i = a;
      io_wdata_i = d;
      io_wr_i = 1'b1;
      step(1);
      io_wr_i = 1'b0;
      step(3);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic h, input logic [7:0] d);
      io_addr_i = a;
      io_rd_i = 1'b1;
      step(1);
      io_rd_i = 1'b0;
      chk("read hit", h, io_hit_o);
      chk("read data", d, io_rdata_o);
      step(1);
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // Watchdog: the tests need well under 2000 cycles
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end

   // Main sequence
   initial begin
      {boot_mode_pin_i, io_wr_i, io_rd_i, csio_tx_b_i} = '0;
      {csio_clock_b_out_i, csio_clock_b_oe_i, port2_func_out_i} = '0;
      {io_addr_i, io_wdata_i, fixed_in_pins_i, port1_func_out_i} = '0;
      {port3_out_i, port3_dir_i, ext3_i, port2_out_i, port2_dir_i} = '0;
      {ext2_i, port1_out_i, port1_dir_i, ext1_i} = '0;
      rst_v = '{SMPS_RST_WAIT_CONFIG, SMPS_RST_IRQ_ROUTING,
         SMPS_RST_PIN_SELECT_B, SMPS_RST_PIN_SELECT_C, SMPS_RST_PIN_SELECT_D};
      step(6);
      rst_n_i = 1'b1;
      step(1);
      chk("io wait", 8'h4, io_wait_o);
      for (int i = 0; i < 5; i++)
         rd({8'h00, SMPS_ADDR_WAIT_CONFIG + 8'(i)}, 1'b1, rst_v[i]);
      rd(16'h001a, 1'b0, 8'h00);
      rd(16'h0020, 1'b0, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         wr({8'h00, SMPS_ADDR_WAIT_CONFIG}, {4'(i), 4'h0});
         chk("io wait", 3'(i[3:2]) + 3'h1, io_wait_o);
         chk("half", i[3:2] == 2'h3, io_strobe_half_delay_o);
         chk("mem lo", i[1:0] != 2'h3, mem_wait_lo_o);
         chk("mem hi", !i[1], mem_wait_hi_o);
      end
      rd({8'h77, SMPS_ADDR_WAIT_CONFIG}, 1'b1, 8'hf0);
      wr({8'ha5, SMPS_ADDR_PIN_SELECT_B}, 8'hc0);
      rd({8'h3c, SMPS_ADDR_PIN_SELECT_B}, 1'b1, 8'hc0);
      chk("pin5 func", 2'h3, pin5_func_o);
      boot_mode_pin_i = 1'b1;
      step(3);
      chk("debug boot", 1'b1, debug_boot_o);
      boot_mode_pin_i = 1'b0;
      step(3);
      chk("debug boot", 1'b0, debug_boot_o);
      $display("test waits and mode done");
      for (int i = 0; i < 2; i++) begin
         fixed_in_pins_i = i ? 4'ha : 4'h5;
         step(3);
         chk("gates", fixed_in_pins_i, timer_gate_o);
         chk("port0", fixed_in_pins_i, port0_in_hi_o);
         chk("uart clk a", fixed_in_pins_i[0], uart_clock_in_a_o);
         chk("uart clk b", fixed_in_pins_i[1], uart_clock_in_b_o);
      end
      // Board drives one pattern, the port the opposite one
      wr({8'h00, SMPS_ADDR_PIN_SELECT_B}, 8'h20);
      ext3_i = 5'h16;
      port3_out_i = 5'h09;
      for (int i = 0; i < 2; i++) begin
         port3_dir_i = i ? 5'h1e : 5'h00;
         step(4);
         e = {i ? port3_out_i : ext3_i, 3'h0};
         chk("csio rx", e[7], csio_rx_b_o);
         chk("uart rx", e[6], uart_rx_b_o);
         chk("cts", e[5], uart_clear_to_send_b_o);
         chk("dsr", e[4], uart_set_ready_b_o);
      end
      wr({8'h00, SMPS_ADDR_PIN_SELECT_D}, 8'h04);
      port3_dir_i = 5'h1f;
      for (int i = 0; i < 2; i++) begin
         csio_tx_b_i = i[0];
         step(4);
         chk("tx pin", i[0], port3_pin_o[3]);
         chk("tx read", i[0], port3_in_o[3]);
      end
      $display("test port3 done");
      wr({8'h00, SMPS_ADDR_PIN_SELECT_B}, 8'h00);
      wr({8'h00, SMPS_ADDR_PIN_SELECT_C}, 8'h80);
      wr({8'h00, SMPS_ADDR_IRQ_ROUTING}, 8'hf0);
      for (int j = 0; j < 4; j++) begin
         if (j == 2)
            wr({8'h00, SMPS_ADDR_IRQ_ROUTING}, 8'hff);
         e = j[0] ? 8'h5a : 8'ha5;
         inv = j[1];
         ext2_i = e;
         port2_func_out_i = e[2:0];
         step(4);
         chk("nmi", e[7], nmi_in_o);
         chk("bus ack", e[6], ext_bus_ack_in_o);
         chk("dma b", e[5], dma_request_b_o);
         chk("dma a", e[4], dma_request_a_o);
         chk("irq15", e[3], irq_line_15_o);
         chk("irq14", e[2], irq_line_14_o);
         chk("irq1", e[1] ^ inv, irq_line_1_o);
         chk("irq5", e[1] ^ inv, irq_line_5_o);
         chk("irq0", e[0] ^ inv, irq_line_0_o);
         chk("irq2", e[0] ^ inv, irq_line_2_o);
         chk("port2 read", e, port2_in_o);
      end
      ext2_i = 8'hff;
      wr({8'h00, SMPS_ADDR_IRQ_ROUTING}, 8'h00);
      wr({8'h00, SMPS_ADDR_PIN_SELECT_C}, 8'h40);
      chk("irq0 off", 1'b0, irq_line_0_o);
      chk("nmi off", 1'b0, nmi_in_o);
      $display("test port2 done");
      wr({8'h00, SMPS_ADDR_PIN_SELECT_D}, 8'h0a);
      port1_func_out_i = 7'h55;
      for (int i = 0; i < 2; i++) begin
         ext1_i = i ? 8'h40 : 8'h41;
         step(4);
         chk("out pins func", 2'h2, out_pins_func_o);
         chk("port1 oe", 8'h42, port1_oe_o);
         chk("forced bit1", 1'b1, port1_pin_o[1]);
         chk("forced bit6", 1'b0, port1_pin_o[6]);
         chk("sck in", ext1_i[0], csio_clock_b_o);
         chk("sck port", ext1_i[0], port1_in_o[0]);
      end
      $display("test port1 done");
      end_of_test();
   end
endmodule : tb
